//--- verilog/pcs_pkg.sv
// Constants and types for the power-up and configuration mode sequencer
`default_nettype none
package pcs_pkg;
  // Clock and power-on reset timing
  localparam longint unsigned CLK_PERIOD_PS = 64'd5000;
  localparam longint unsigned PS_PER_MS     = 64'd1000000000;
  localparam longint unsigned POR_LONG_MS   = 64'd100;
  localparam longint unsigned POR_SHORT_MS  = 64'd12;
  localparam longint unsigned POR_LONG_CYC  =
    (POR_LONG_MS * PS_PER_MS + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS;
  localparam longint unsigned POR_SHORT_CYC =
    (POR_SHORT_MS * PS_PER_MS + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS;
  localparam int              POR_CNT_W     = 25;

  // Initialization phase lengths in cycles
  localparam int              INIT_CNT_W     = 4;
  localparam logic [3:0]      INIT_CLEAR_CYC = 4'h4;
  localparam logic [3:0]      INIT_IO_CYC    = 4'h4;

  // Register map, byte addresses
  localparam int              ADDR_W       = 12;
  localparam logic [11:0]     OFS_CTRL     = 12'h000;
  localparam logic [11:0]     OFS_LENGTH   = 12'h004;
  localparam logic [11:0]     OFS_DATA     = 12'h008;
  localparam logic [11:0]     OFS_STATUS   = 12'h00C;
  localparam logic [11:0]     OFS_CHECKSUM = 12'h010;

  // Field layout
  localparam int              SCHEME_W       = 3;
  localparam int              WORD_CNT_W     = 16;
  localparam logic [15:0]     LENGTH_RST     = 16'h0004;
  localparam int              STAT_STATE_LSB = 0;
  localparam int              STAT_CMD_BIT   = 5;
  localparam int              STAT_USER_BIT  = 6;
  localparam int              STAT_BUF_BIT   = 7;
  localparam int              STAT_POR_BIT   = 8;
  localparam int              STAT_LOAD_BIT  = 9;
  localparam int              STAT_SCH_LSB   = 10;
  localparam int              STAT_CNT_LSB   = 16;

  // Configuration schemes
  localparam logic [2:0] FAST_PASSIVE_PARALLEL_SCHEME  = 3'h0;
  localparam logic [2:0] ACTIVE_SERIAL_SCHEME          = 3'h1;
  localparam logic [2:0] PASSIVE_SERIAL_SCHEME         = 3'h2;
  localparam logic [2:0] PASSIVE_PARALLEL_ASYNC_SCHEME = 3'h3;
  localparam logic [2:0] BOUNDARY_SCAN_SCHEME          = 3'h4;

  // Sequencer states
  typedef enum logic [4:0] {
    ST_POR        = 5'h01,
    ST_CONFIG     = 5'h02,
    ST_INIT_CLEAR = 5'h04,
    ST_INIT_IO    = 5'h08,
    ST_USER       = 5'h10
  } pcs_state_t;

  // Pin synchroniser lanes
  localparam int         PIN_W       = 5;
  localparam int         PIN_POR     = 0;
  localparam int         PIN_PULL    = 1;
  localparam int         PIN_BUF     = 2;
  localparam int         PIN_RECFG_N = 3;
  localparam int         PIN_PLL     = 4;
  localparam logic [4:0] PIN_RST     = 5'h08;
endpackage
`default_nettype wire

//--- verilog/pcs_sync.sv
// Two-flop synchroniser, one lane per bit
`timescale 1ns/1ps
`default_nettype none
module pcs_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic [W-1:0]   d,
  output logic      [W-1:0]   q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_lane
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_r[i] <= RST_VAL[i];
          sync_r[i] <= RST_VAL[i];
        end
        else
        begin
          meta_r[i] <= d[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign q = sync_r;
endmodule // pcs_sync
`default_nettype wire

//--- verilog/pcs_sequencer.sv
// Power-up and configuration mode sequencer with APB register access
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pcs_sequencer #(
  parameter int unsigned POR_LONG_CYCLES  = int'(pcs_pkg::POR_LONG_CYC),
  parameter int unsigned POR_SHORT_CYCLES = int'(pcs_pkg::POR_SHORT_CYC)
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic [pcs_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       por_delay_select,
  input  wire logic                       config_weak_pull_select,
  input  wire logic                       input_buffer_select,
  input  wire logic                       reconfig_request_pin_n,
  input  wire logic                       pll_enable_input,
  output logic                            io_output_enable,
  output logic                            weak_pullup_enable,
  output logic                            low_voltage_buffer_select,
  output logic                            high_voltage_buffer_select,
  output logic                            pll_enable_lv_path,
  output logic                            pll_enable_hv_path,
  output logic                            command_mode,
  output logic                            user_mode,
  output logic                            user_reset_n
);

  // Synchronised pins
  logic [pcs_pkg::PIN_W-1:0]      pins_raw;
  logic [pcs_pkg::PIN_W-1:0]      pins_s;
  logic                           por_sel_s;
  logic                           pull_sel_s;
  logic                           buf_sel_s;
  logic                           recfg_n_s;
  logic                           pll_en_s;

  // Sequencer state
  pcs_pkg::pcs_state_t            state_r;
  pcs_pkg::pcs_state_t            state_nxt;
  logic [pcs_pkg::POR_CNT_W-1:0]  por_cnt_r;
  logic [pcs_pkg::POR_CNT_W-1:0]  por_limit;
  logic                           por_done;
  logic [pcs_pkg::INIT_CNT_W-1:0] init_cnt_r;
  logic                           init_done;

  // Configuration load state
  logic [pcs_pkg::SCHEME_W-1:0]   scheme_r;
  logic [pcs_pkg::WORD_CNT_W-1:0] length_r;
  logic [pcs_pkg::WORD_CNT_W-1:0] word_cnt_r;
  logic [pcs_pkg::WORD_CNT_W-1:0] word_cnt_inc;
  logic [31:0]                    checksum_r;
  logic                           loaded_r;
  logic                           buf_sel_r;
  logic                           cfg_last;

  // Bus decode
  logic                           setup_ph;
  logic                           access_ph;
  logic                           wr_en;
  logic                           hit_ctrl;
  logic                           hit_length;
  logic                           hit_data;
  logic                           hit_status;
  logic                           hit_checksum;
  logic                           hit_any;
  logic                           data_wr;
  logic                           scheme_ok;
  logic [31:0]                    rd_mux;
  logic [31:0]                    status_word;
  logic [31:0]                    prdata_r;

  // Registered outputs
  logic                           io_oe_r;
  logic                           weak_pull_r;
  logic                           lv_sel_r;
  logic                           hv_sel_r;
  logic                           pll_lv_r;
  logic                           pll_hv_r;
  logic                           cmd_mode_r;
  logic                           user_mode_r;
  logic                           user_rst_n_r;

  assign pins_raw[pcs_pkg::PIN_POR]     = por_delay_select;
  assign pins_raw[pcs_pkg::PIN_PULL]    = config_weak_pull_select;
  assign pins_raw[pcs_pkg::PIN_BUF]     = input_buffer_select;
  assign pins_raw[pcs_pkg::PIN_RECFG_N] = reconfig_request_pin_n;
  assign pins_raw[pcs_pkg::PIN_PLL]     = pll_enable_input;

  pcs_sync #(
    .W       (pcs_pkg::PIN_W),
    .RST_VAL (pcs_pkg::PIN_RST)
  ) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pins_raw),
    .q     (pins_s)
  );

  assign por_sel_s  = pins_s[pcs_pkg::PIN_POR];
  assign pull_sel_s = pins_s[pcs_pkg::PIN_PULL];
  assign buf_sel_s  = pins_s[pcs_pkg::PIN_BUF];
  assign recfg_n_s  = pins_s[pcs_pkg::PIN_RECFG_N];
  assign pll_en_s   = pins_s[pcs_pkg::PIN_PLL];

  // APB decode
  assign setup_ph     = psel && !penable;
  assign access_ph    = psel && penable;
  assign wr_en        = access_ph && pwrite;
  assign hit_ctrl     = (paddr == pcs_pkg::OFS_CTRL);
  assign hit_length   = (paddr == pcs_pkg::OFS_LENGTH);
  assign hit_data     = (paddr == pcs_pkg::OFS_DATA);
  assign hit_status   = (paddr == pcs_pkg::OFS_STATUS);
  assign hit_checksum = (paddr == pcs_pkg::OFS_CHECKSUM);
  assign hit_any      = hit_ctrl || hit_length || hit_data || hit_status || hit_checksum;
  assign pready       = 1'b1;
  assign pslverr      = access_ph && !hit_any;
  assign prdata       = prdata_r;

  // Config words only count while configuring and not held in reconfiguration
  assign data_wr      = wr_en && hit_data && (state_r == pcs_pkg::ST_CONFIG) && recfg_n_s;
  assign word_cnt_inc = word_cnt_r + {{(pcs_pkg::WORD_CNT_W-1){1'b0}}, 1'b1};
  assign cfg_last     = data_wr && (length_r != '0) && (word_cnt_inc == length_r);

  // Power-on delay chosen by the delay select pin
  assign por_limit = por_sel_s ? pcs_pkg::POR_CNT_W'(POR_SHORT_CYCLES - 1)
                               : pcs_pkg::POR_CNT_W'(POR_LONG_CYCLES - 1);
  assign por_done  = (state_r == pcs_pkg::ST_POR) && (por_cnt_r >= por_limit);

  assign init_done = ((state_r == pcs_pkg::ST_INIT_CLEAR) &&
                      (init_cnt_r == pcs_pkg::INIT_CLEAR_CYC - 4'h1)) ||
                     ((state_r == pcs_pkg::ST_INIT_IO) &&
                      (init_cnt_r == pcs_pkg::INIT_IO_CYC - 4'h1));

  // Mode sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      pcs_pkg::ST_POR:
      begin
        if (por_done)
        begin
          state_nxt = pcs_pkg::ST_CONFIG;
        end
      end
      pcs_pkg::ST_CONFIG:
      begin
        if (cfg_last)
        begin
          state_nxt = pcs_pkg::ST_INIT_CLEAR;
        end
      end
      pcs_pkg::ST_INIT_CLEAR:
      begin
        if (!recfg_n_s)
        begin
          state_nxt = pcs_pkg::ST_CONFIG;
        end
        else if (init_done)
        begin
          state_nxt = pcs_pkg::ST_INIT_IO;
        end
      end
      pcs_pkg::ST_INIT_IO:
      begin
        if (!recfg_n_s)
        begin
          state_nxt = pcs_pkg::ST_CONFIG;
        end
        else if (init_done)
        begin
          state_nxt = pcs_pkg::ST_USER;
        end
      end
      pcs_pkg::ST_USER:
      begin
        if (!recfg_n_s)
        begin
          state_nxt = pcs_pkg::ST_CONFIG;
        end
      end
      default:
      begin
        state_nxt = pcs_pkg::ST_POR;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= pcs_pkg::ST_POR;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Power-on delay counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_cnt_r <= '0;
    end
    else if (state_r == pcs_pkg::ST_POR)
    begin
      por_cnt_r <= por_cnt_r + {{(pcs_pkg::POR_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Initialization phase counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_cnt_r <= '0;
    end
    else if (state_nxt != state_r)
    begin
      init_cnt_r <= '0;
    end
    else if ((state_r == pcs_pkg::ST_INIT_CLEAR) || (state_r == pcs_pkg::ST_INIT_IO))
    begin
      init_cnt_r <= init_cnt_r + {{(pcs_pkg::INIT_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Buffer select caught once, as power-on delay ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buf_sel_r <= 1'b0;
    end
    else if (por_done)
    begin
      buf_sel_r <= buf_sel_s;
    end
  end

  // Configuration word loading
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_cnt_r <= '0;
      checksum_r <= '0;
      loaded_r   <= 1'b0;
    end
    else if ((state_nxt == pcs_pkg::ST_CONFIG) &&
             ((state_r != pcs_pkg::ST_CONFIG) || !recfg_n_s))
    begin
      word_cnt_r <= '0;
      checksum_r <= '0;
      loaded_r   <= 1'b0;
    end
    else if (data_wr)
    begin
      word_cnt_r <= word_cnt_inc;
      checksum_r <= checksum_r ^ pwdata;
      loaded_r   <= cfg_last;
    end
  end

  // Control registers
  assign scheme_ok = (pwdata[pcs_pkg::SCHEME_W-1:0] <= pcs_pkg::BOUNDARY_SCAN_SCHEME);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scheme_r <= pcs_pkg::FAST_PASSIVE_PARALLEL_SCHEME;
      length_r <= pcs_pkg::LENGTH_RST;
    end
    else if (wr_en && (state_r != pcs_pkg::ST_USER))
    begin
      if (hit_ctrl && scheme_ok)
      begin
        scheme_r <= pwdata[pcs_pkg::SCHEME_W-1:0];
      end
      else if (hit_length && (state_r != pcs_pkg::ST_CONFIG))
      begin
        length_r <= pwdata[pcs_pkg::WORD_CNT_W-1:0];
      end
    end
  end

  // Read path, registered in the setup phase
  always_comb
  begin
    status_word = '0;
    status_word[pcs_pkg::STAT_STATE_LSB +: 5]           = state_r;
    status_word[pcs_pkg::STAT_CMD_BIT]                  = cmd_mode_r;
    status_word[pcs_pkg::STAT_USER_BIT]                 = user_mode_r;
    status_word[pcs_pkg::STAT_BUF_BIT]                  = buf_sel_r;
    status_word[pcs_pkg::STAT_POR_BIT]                  = por_sel_s;
    status_word[pcs_pkg::STAT_LOAD_BIT]                 = loaded_r;
    status_word[pcs_pkg::STAT_SCH_LSB +: pcs_pkg::SCHEME_W] = scheme_r;
    status_word[pcs_pkg::STAT_CNT_LSB +: pcs_pkg::WORD_CNT_W] = word_cnt_r;
  end

  always_comb
  begin
    rd_mux = '0;
    if (hit_ctrl)
    begin
      rd_mux[pcs_pkg::SCHEME_W-1:0] = scheme_r;
    end
    else if (hit_length)
    begin
      rd_mux[pcs_pkg::WORD_CNT_W-1:0] = length_r;
    end
    else if (hit_status)
    begin
      rd_mux = status_word;
    end
    else if (hit_checksum)
    begin
      rd_mux = checksum_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= '0;
    end
    else if (setup_ph)
    begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // Pin-facing outputs follow the next state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_oe_r      <= 1'b0;
      weak_pull_r  <= 1'b0;
      cmd_mode_r   <= 1'b1;
      user_mode_r  <= 1'b0;
      user_rst_n_r <= 1'b0;
    end
    else
    begin
      io_oe_r      <= (state_nxt == pcs_pkg::ST_INIT_IO) ||
                      (state_nxt == pcs_pkg::ST_USER);
      weak_pull_r  <= ((state_nxt == pcs_pkg::ST_POR) ||
                       (state_nxt == pcs_pkg::ST_CONFIG)) && !pull_sel_s;
      cmd_mode_r   <= (state_nxt != pcs_pkg::ST_USER);
      user_mode_r  <= (state_nxt == pcs_pkg::ST_USER);
      user_rst_n_r <= (state_nxt == pcs_pkg::ST_USER);
    end
  end

  // Buffer routing from the latched select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lv_sel_r <= 1'b0;
      hv_sel_r <= 1'b1;
      pll_lv_r <= 1'b0;
      pll_hv_r <= 1'b0;
    end
    else
    begin
      lv_sel_r <= buf_sel_r;
      hv_sel_r <= !buf_sel_r;
      pll_lv_r <= pll_en_s && buf_sel_r;
      pll_hv_r <= pll_en_s && !buf_sel_r;
    end
  end

  assign io_output_enable           = io_oe_r;
  assign weak_pullup_enable         = weak_pull_r;
  assign low_voltage_buffer_select  = lv_sel_r;
  assign high_voltage_buffer_select = hv_sel_r;
  assign pll_enable_lv_path         = pll_lv_r;
  assign pll_enable_hv_path         = pll_hv_r;
  assign command_mode               = cmd_mode_r;
  assign user_mode                  = user_mode_r;
  assign user_reset_n               = user_rst_n_r;

endmodule // pcs_sequencer
`default_nettype wire

//--- verilog/pcs_fix_note.sv
// Intentionally empty compilation unit
`default_nettype none
`default_nettype wire

//--- dv/pcs_sequencer_asserts.sv
// Port assertions for the mode sequencer
`timescale 1ns/1ps
`default_nettype none
module pcs_sequencer_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reconfig_request_pin_n,
  input wire logic io_output_enable,
  input wire logic weak_pullup_enable,
  input wire logic low_voltage_buffer_select,
  input wire logic high_voltage_buffer_select,
  input wire logic pll_enable_lv_path,
  input wire logic pll_enable_hv_path,
  input wire logic command_mode,
  input wire logic user_mode,
  input wire logic user_reset_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence io_up_s;
    $rose(io_output_enable) && command_mode;
  endsequence
  sequence init_io_s;
    command_mode [*4] ##1 user_mode;
  endsequence
  sequence recfg_s;
    !reconfig_request_pin_n [*4];
  endsequence
  AST_MODE_ONE: assert property (command_mode != user_mode)
    else $error("command and user mode not exclusive");
  AST_USER_RST: assert property (user_reset_n == user_mode)
    else $error("user reset not tied to user mode");
  AST_USER_IO: assert property (user_mode |-> io_output_enable)
    else $error("io off in user mode");
  AST_PULL_CMD: assert property (weak_pullup_enable |-> command_mode && !io_output_enable)
    else $error("pull-up outside config phase");
  AST_INIT_SEQ: assert property (io_up_s |-> init_io_s)
    else $error("io enable phase length wrong");
  AST_RECFG: assert property (recfg_s |-> command_mode && !io_output_enable)
    else $error("reconfig request not honoured");
  AST_BUF_COMP: assert property (low_voltage_buffer_select != high_voltage_buffer_select)
    else $error("buffer selects not complementary");
  AST_BUF_HOLD: assert property (user_mode |-> $stable(low_voltage_buffer_select))
    else $error("buffer select changed after latch");
  AST_PLL_ROUTE: assert property (!(pll_enable_lv_path && high_voltage_buffer_select)
    && !(pll_enable_hv_path && low_voltage_buffer_select))
    else $error("pll enable on wrong buffer path");
endmodule // pcs_sequencer_asserts
bind pcs_sequencer pcs_sequencer_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .reconfig_request_pin_n(reconfig_request_pin_n),
  .io_output_enable(io_output_enable), .weak_pullup_enable(weak_pullup_enable),
  .low_voltage_buffer_select(low_voltage_buffer_select),
  .high_voltage_buffer_select(high_voltage_buffer_select),
  .pll_enable_lv_path(pll_enable_lv_path), .pll_enable_hv_path(pll_enable_hv_path),
  .command_mode(command_mode), .user_mode(user_mode), .user_reset_n(user_reset_n)
);
`default_nettype wire

//--- dv/pcs_cfg_host.sv
// Configuration host model: APB writer and reconfig pin driver
`timescale 1ns/1ps
`default_nettype none
module pcs_cfg_host (
  input  wire logic                       pclk,
  output logic      [pcs_pkg::ADDR_W-1:0] paddr,
  output logic                            psel,
  output logic                            penable,
  output logic                            pwrite,
  output logic      [31:0]                pwdata,
  input  wire logic [31:0]                prdata,
  input  wire logic                       pready,
  input  wire logic                       pslverr,
  output logic                            reconfig_request_pin_n
);
  localparam int CHAIN_POS = 1;
  initial
  begin
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = '0;
    reconfig_request_pin_n = 1'b1;
  end
  // One word per transfer, data port is one location
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic recfg(input int n);
    @(posedge pclk);
    reconfig_request_pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    reconfig_request_pin_n <= 1'b1;
  endtask
endmodule // pcs_cfg_host
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr;
  logic        psel, penable, pwrite, pready, pslverr, recfg_n;
  logic [31:0] pwdata, prdata, rd, d, exp_sum;
  logic        por_sel = 1'b1, pull_sel = 1'b0, buf_sel = 1'b1, pll_in = 1'b0;
  logic        io_oe, wpu, lv, hv, pll_lv, pll_hv, cmd, usr, urst_n, err, lat;
  logic [2:0]  exp_sch;
  int          mismatches = 0, num_checks = 0, exp_cnt, exp_len;
  always #2.5 pclk = ~pclk;
  pcs_cfg_host host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reconfig_request_pin_n(recfg_n));
  pcs_sequencer #(.POR_LONG_CYCLES(40), .POR_SHORT_CYCLES(10)) dut (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_delay_select(por_sel), .config_weak_pull_select(pull_sel),
    .input_buffer_select(buf_sel), .reconfig_request_pin_n(recfg_n),
    .pll_enable_input(pll_in), .io_output_enable(io_oe), .weak_pullup_enable(wpu),
    .low_voltage_buffer_select(lv), .high_voltage_buffer_select(hv),
    .pll_enable_lv_path(pll_lv), .pll_enable_hv_path(pll_hv), .command_mode(cmd),
    .user_mode(usr), .user_reset_n(urst_n));
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("[ERR] %0t reg got %h exp %h", $time, g, x);
    end
  endtask
  task automatic chk_pin(input logic [8:0] g, input logic [8:0] x);
    num_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("[ERR] %0t pins got %h exp %h", $time, g, x);
    end
  endtask
  task automatic see(input logic io, input logic w, input logic lvs, input logic u);
    @(negedge pclk);
    chk_pin({io_oe, wpu, lv, hv, pll_lv, pll_hv, cmd, usr, urst_n},
            {io, w, lvs, !lvs, pll_in & lvs, pll_in & !lvs, !u, u, u});
  endtask
  function automatic logic [31:0] stat(input logic [4:0] st, input logic ld);
    return {exp_cnt[15:0], 3'h0, exp_sch, ld, por_sel, lat, st == 5'h10, st != 5'h10, st};
  endfunction
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    host.xfer(1'b0, a, 32'h0, rd, err);
    chk_reg(rd, x);
    chk_reg({31'h0, err}, {31'h0, xe});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, rd, err);
  endtask
  task automatic boot(input logic ps, input logic pu, input logic bs, input int c);
    @(posedge pclk);
    presetn  <= 1'b0;
    por_sel  <= ps;
    pull_sel <= pu;
    buf_sel  <= bs;
    pll_in   <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    exp_len = 4;
    exp_cnt = 0;
    exp_sum = 32'h0;
    exp_sch = 3'h0;
    lat = 1'b0;
    if (c == 10)
    begin
      wr(pcs_pkg::OFS_LENGTH, 32'h3);
      exp_len = 3;
    end
    see(1'b0, !pu, 1'b0, 1'b0);
    repeat (c - 9) @(posedge pclk);
    rd_chk(pcs_pkg::OFS_STATUS, stat(5'h01, 1'b0), 1'b0);
    lat = bs;
    repeat (8) @(posedge pclk);
    rd_chk(pcs_pkg::OFS_STATUS, stat(5'h02, 1'b0), 1'b0);
    buf_sel <= !bs;
    see(1'b0, !pu, bs, 1'b0);
  endtask
  task automatic cfg;
    repeat (4) @(posedge pclk);
    while (exp_cnt < exp_len)
    begin
      d = $urandom;
      wr(pcs_pkg::OFS_DATA, d);
      exp_sum ^= d;
      exp_cnt++;
    end
    see(1'b0, 1'b0, lat, 1'b0);
    repeat (12) @(posedge pclk);
    see(1'b1, 1'b0, lat, 1'b1);
    rd_chk(pcs_pkg::OFS_STATUS, stat(5'h10, 1'b1), 1'b0);
    rd_chk(pcs_pkg::OFS_CHECKSUM, exp_sum, 1'b0);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(99013));
    boot(1'b1, 1'b0, 1'b1, 10);
    rd_chk(pcs_pkg::OFS_LENGTH, 32'h3, 1'b0);
    wr(pcs_pkg::OFS_LENGTH, 32'h7);
    rd_chk(pcs_pkg::OFS_LENGTH, 32'h3, 1'b0);
    for (int s = 0; s < 6; s++)
    begin
      wr(pcs_pkg::OFS_CTRL, s);
      if (s < 5)
        exp_sch = s[2:0];
      rd_chk(pcs_pkg::OFS_CTRL, {29'h0, exp_sch}, 1'b0);
    end
    rd_chk(12'h020, 32'h0, 1'b1);
    cfg();
    wr(pcs_pkg::OFS_DATA, 32'h0000_00FF);
    wr(pcs_pkg::OFS_CTRL, 32'h1);
    rd_chk(pcs_pkg::OFS_STATUS, stat(5'h10, 1'b1), 1'b0);
    pll_in <= 1'b1;
    repeat (4) @(posedge pclk);
    see(1'b1, 1'b0, lat, 1'b1);
    host.recfg(6);
    exp_cnt = 0;
    exp_sum = 32'h0;
    see(1'b0, 1'b1, lat, 1'b0);
    rd_chk(pcs_pkg::OFS_STATUS, stat(5'h02, 1'b0), 1'b0);
    cfg();
    boot(1'b0, 1'b1, 1'b0, 40);
    pll_in <= 1'b1;
    cfg();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
